//--- eeps_pkg.sv
// Package of constants for the nonvolatile erase and program sequencer.
package eeps_pkg;
   localparam logic [15:0] PROG_CTRL_ADDR   = 16'h103B;
   localparam logic [7:0]  PROG_CTRL_RESET  = 8'h00;
   // Control register field positions.
   localparam int          BIT_VOLTAGE      = 0;
   localparam int          BIT_LATCH        = 1;
   localparam int          BIT_ERASE        = 2;
   localparam int          BIT_ROW          = 3;
   localparam int          BIT_BYTE         = 4;
   localparam int          BIT_ELAT         = 5;
   localparam int          BIT_EVEN         = 6;
   localparam int          BIT_ODD          = 7;
   // Array window and option word address.
   localparam logic [15:0] ARRAY_BASE       = 16'hB600;
   localparam int          ARRAY_BYTES      = 512;
   localparam int          ROW_BYTES        = 16;
   localparam logic [15:0] OPTION_WORD_ADDR = 16'h103F;
   localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
   // High voltage phase time.
   localparam int          HV_TIME_MS       = 10;
   localparam int          CLK_MHZ          = 100;
   localparam int          HV_CYCLES        = HV_TIME_MS * 1000 * CLK_MHZ;

   typedef enum logic [1:0] {
      EEPS_IDLE,
      EEPS_LATCHED,
      EEPS_HV
   } eeps_state_t;
endpackage

//--- eeps_cells.sv
// Nonvolatile array cells with erase by scope and single-byte program; reset loads the option word erased.
module eeps_cells
   import eeps_pkg::*;
#(
   parameter int DEPTH = eeps_pkg::ARRAY_BYTES
) (
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     commit,
   input  wire logic                     erase,
   input  wire logic                     scope_byte,
   input  wire logic                     scope_row,
   input  wire logic                     option_sel,
   input  wire logic [$clog2(DEPTH)-1:0] tgt_index,
   input  wire logic [7:0]               tgt_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_index,
   output logic      [7:0]               rd_data,
   output logic      [7:0]               option_word
);
   localparam int AW = $clog2(DEPTH);
   localparam int RW = $clog2(eeps_pkg::ROW_BYTES);

   // Row scope compares index bits above the row, so only whole rows can be served.
   if (DEPTH < eeps_pkg::ROW_BYTES || (DEPTH % eeps_pkg::ROW_BYTES) != 0) begin : g_bad_depth
      $error("Array depth must be a whole number of rows.");
   end

   logic [7:0] mem [DEPTH];

   // Decides whether a cell index falls inside the committed erase scope.
   function automatic logic in_scope(input logic [AW-1:0] idx);
      if (scope_byte)
         return idx == tgt_index;
      else if (scope_row)
         return idx[AW-1:RW] == tgt_index[AW-1:RW];
      else
         return 1'b1;
   endfunction

   // Programming only clears bits, so a cell must be erased before it takes ones.
   generate
      for (genvar i = 0; i < DEPTH; i++) begin : g_cell
         always_ff @(posedge clk) begin
            if (commit && !option_sel) begin
               if (erase && in_scope(AW'(i))) // RULE_12
                  mem[i] <= ERASED_BYTE;
               else if (!erase && tgt_index == AW'(i))
                  mem[i] <= mem[i] & tgt_data;
            end
         end
      end
   endgenerate

   // Option word shares the cell behaviour, always addressed as one byte.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         option_word <= ERASED_BYTE;
      else if (commit && option_sel)
         option_word <= erase ? ERASED_BYTE : (option_word & tgt_data); // RULE_07
   end

   always_ff @(posedge clk) begin
      rd_data <= mem[rd_index];
   end
endmodule

//--- eeps_sequencer.sv
// Erase and program sequencer with its programming control register.
// Operation
// RULE_01: Software writes row, erase and latch bits before writing the array.
// RULE_02: Row mode takes any data at any row address only to select row.
// RULE_03: Software then sets voltage enable keeping row, erase and latch bits.
// RULE_04: Voltage phase lasts 10 ms; clearing register ends it and restores reads.
// RULE_05: Byte erase sets byte, erase, latch, then writes the target byte address.
// RULE_06: Byte erase then adds voltage enable, waits, then clears register.
// RULE_07: Option word uses byte sequences at its own address.
// RULE_08: Option word changes allowed in any mode only while protect is clear.
// RULE_09: Software erases, programs option word, then resets; no early reset.
// RULE_10: Security on a ROM part confines operation to single-chip modes.
// RULE_11: Under security internal code keeps full array and RAM access.
// RULE_12: Byte bit erases one byte, row bit a 16-byte row, else all.
// RULE_13: One write setting latch and voltage enable together sets neither.
// RULE_14: With latch set the array is unreadable; clear, it reads as ROM.
// RULE_15: Array writes with latch set go to latches, not the array.
module eeps_sequencer
   import eeps_pkg::*;
#(
   parameter int ARRAY_DEPTH = eeps_pkg::ARRAY_BYTES,
   parameter int HV_COUNT    = eeps_pkg::HV_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   output logic      [7:0]  bus_rdata,
   output logic             bus_hit,
   input  wire logic        option_word_protect,
   input  wire logic [3:0]  block_protect_control,
   input  wire logic        security_enable,
   input  wire logic        rom_based_part,
   input  wire logic        mode_expanded_req,
   output logic             mode_expanded,
   output logic             program_voltage_on,
   output logic             hv_time_done,
   output logic             write_rejected,
   output logic [7:0]       option_word
);
   import eeps_pkg::*;

   localparam int AW = $clog2(ARRAY_DEPTH);
   localparam int CW = $clog2(HV_COUNT + 1);

   // The quarter decode takes the top two index bits, so the depth must be a power of two.
   if (HV_COUNT < 1) begin : g_bad_count
      $error("Voltage phase count must be at least one cycle.");
   end
   if (ARRAY_DEPTH < ROW_BYTES || (ARRAY_DEPTH & (ARRAY_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("Array depth must be a power of two of at least one row.");
   end

   logic [7:0]              programming_control;
   eeps_state_t             state;
   eeps_state_t             next_state;
   logic [AW-1:0]           latch_index;
   logic [7:0]              latch_data;
   logic                    latch_option;
   logic [CW-1:0]           hv_count;
   logic                    commit;
   logic [7:0]              cell_rdata;
   logic                    rd_pend;
   logic                    rd_pend_array;
   logic [7:0]              reg_rdata;

   // Decodes which protect bit covers an array index, split in four quarters.
   function automatic logic block_locked(input logic [AW-1:0] idx);
      return block_protect_control[idx[AW-1:AW-2]];
   endfunction

   // Address decode.
   wire        ctrl_hit     = (bus_addr == PROG_CTRL_ADDR);
   wire        array_hit    = (bus_addr >= ARRAY_BASE) &&
                              (bus_addr < ARRAY_BASE + 16'(ARRAY_DEPTH));
   wire        option_hit   = (bus_addr == OPTION_WORD_ADDR);
   wire [AW-1:0] arr_index  = AW'(bus_addr - ARRAY_BASE);
   wire        latch_on     = programming_control[BIT_LATCH];
   wire        voltage_on   = programming_control[BIT_VOLTAGE];
   wire        ctrl_wr      = bus_write && ctrl_hit;

   // A write that asks for latch and voltage together while latch is clear is refused for both bits.
   wire        both_req     = bus_wdata[BIT_LATCH] && bus_wdata[BIT_VOLTAGE]; // RULE_13
   // Voltage may only be added once latch is already set and a target is held.
   wire        volt_allowed = latch_on && (state == EEPS_LATCHED);
   wire [7:0]  next_ctrl_wr = both_req && !latch_on ?
                              (bus_wdata & ~8'h03) :
                              {bus_wdata[7:1], bus_wdata[BIT_VOLTAGE] && volt_allowed};

   // Target capture; option word is gated by its protect bit.
   wire        opt_wr_ok    = option_hit && !option_word_protect; // RULE_08
   wire        arr_wr_ok    = array_hit && !block_locked(arr_index);
   wire        latch_wr     = bus_write && latch_on && !voltage_on &&
                              (opt_wr_ok || arr_wr_ok); // RULE_15
   wire        bad_wr       = bus_write && latch_on && !voltage_on &&
                              ((option_hit && option_word_protect) ||
                               (array_hit && block_locked(arr_index)));

   // Security keeps the part in single-chip mode on ROM-based parts.
   assign mode_expanded = mode_expanded_req && !(security_enable && rom_based_part); // RULE_10

   // Control register update.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         programming_control <= PROG_CTRL_RESET;
      else if (ctrl_wr)
         programming_control <= next_ctrl_wr; // RULE_03
   end

   // Sequence state; clearing the register at any point returns to idle.
   always_comb begin
      next_state = state;
      case (state)
         EEPS_IDLE:    if (latch_wr) next_state = EEPS_LATCHED; // RULE_02
         EEPS_LATCHED: begin
            if (ctrl_wr && next_ctrl_wr[BIT_VOLTAGE])
               next_state = EEPS_HV;
            else if (ctrl_wr && !next_ctrl_wr[BIT_LATCH])
               next_state = EEPS_IDLE;
         end
         EEPS_HV:      if (ctrl_wr && !next_ctrl_wr[BIT_VOLTAGE]) next_state = EEPS_IDLE; // RULE_04
         default:      next_state = EEPS_IDLE;
      endcase
      if (ctrl_wr && !next_ctrl_wr[BIT_LATCH])
         next_state = EEPS_IDLE;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         state <= EEPS_IDLE;
      else
         state <= next_state;
   end

   // Each latched write retakes the target, so the last one before the voltage wins.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_index  <= '0;
         latch_data   <= ERASED_BYTE;
         latch_option <= 1'b0;
      end else if (latch_wr) begin
         latch_index  <= arr_index; // RULE_05
         latch_data   <= bus_wdata;
         latch_option <= option_hit;
      end
   end

   // Timer for the voltage phase; cells commit on the clearing write once the full time has elapsed.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         hv_count <= '0;
      else if (state != EEPS_HV)
         hv_count <= '0;
      else if (hv_count != CW'(HV_COUNT))
         hv_count <= hv_count + CW'(1); // RULE_04
   end

   // A phase cut short by an early clear is not committed, leaving cells untouched.
   assign hv_time_done       = (state == EEPS_HV) && (hv_count == CW'(HV_COUNT));
   assign commit             = hv_time_done && ctrl_wr && !next_ctrl_wr[BIT_VOLTAGE];
   assign program_voltage_on = voltage_on;
   assign write_rejected     = bad_wr;

   eeps_cells #(
      .DEPTH (ARRAY_DEPTH)
   ) u_cells (
      .clk         (clk),
      .reset_n     (reset_n),
      .commit      (commit),
      .erase       (programming_control[BIT_ERASE]),
      .scope_byte  (programming_control[BIT_BYTE]),
      .scope_row   (programming_control[BIT_ROW]),
      .option_sel  (latch_option), // RULE_07
      .tgt_index   (latch_index),
      .tgt_data    (latch_data),
      .rd_index    (arr_index),
      .rd_data     (cell_rdata),
      .option_word (option_word)
   );

   // Resident code reads freely; with latch set the array returns nothing.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_pend       <= 1'b0;
         rd_pend_array <= 1'b0;
         reg_rdata     <= 8'h00;
      end else begin
         rd_pend       <= bus_read && (ctrl_hit || array_hit || option_hit);
         rd_pend_array <= bus_read && array_hit && !latch_on; // RULE_14
         reg_rdata     <= ctrl_hit ? programming_control :
                          option_hit ? option_word : 8'h00; // RULE_11
      end
   end

   // Read data arrives one cycle after the read strobe.
   assign bus_rdata = rd_pend_array ? cell_rdata : reg_rdata;
   assign bus_hit   = rd_pend;
endmodule

//--- eeps_sequencer_assertions.sv
// Port checker for the erase and program sequencer.
module eeps_checker
   import eeps_pkg::*;
#(
   parameter int HV_COUNT = 20
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic [15:0] bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   input  wire logic [7:0]  bus_rdata,
   input  wire logic        bus_hit,
   input  wire logic        option_word_protect,
   input  wire logic [3:0]  block_protect_control,
   input  wire logic        security_enable,
   input  wire logic        rom_based_part,
   input  wire logic        mode_expanded,
   input  wire logic        program_voltage_on,
   input  wire logic        hv_time_done,
   input  wire logic        write_rejected,
   input  wire logic [7:0]  option_word
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HV_MAX = HV_COUNT + 4;
   // Decodes shared by the properties; the array spans one 512-byte page.
   wire ctrl_wr = bus_write && (bus_addr == PROG_CTRL_ADDR);
   wire arr_rd  = bus_read && (bus_addr[15:9] == ARRAY_BASE[15:9]);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_hv_cause;
      $rose(program_voltage_on) |-> $past(ctrl_wr && bus_wdata[0]);
   endproperty
   a_hv_cause: assert property (p_hv_cause) else $error("voltage rose unasked");
   property p_hv_time;
      $rose(program_voltage_on) |-> (!hv_time_done)[*8] ##[1:HV_MAX] hv_time_done;
   endproperty
   a_hv_time: assert property (p_hv_time) else $error("voltage time wrong");
   property p_clear;
      ctrl_wr && bus_wdata == 8'h00 |=> !program_voltage_on && !hv_time_done;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left voltage on");
   property p_locked_read;
      program_voltage_on && arr_rd |=> bus_rdata == 8'h00;
   endproperty
   a_locked_read: assert property (p_locked_read) else $error("array readable");
   property p_array_hit;
      arr_rd |=> bus_hit;
   endproperty
   a_array_hit: assert property (p_array_hit) else $error("array read missed");
   property p_single_chip;
      security_enable && rom_based_part |-> !mode_expanded;
   endproperty
   a_single_chip: assert property (p_single_chip) else $error("bus exposed");
   property p_opt_protect;
      $changed(option_word) |-> !$past(option_word_protect);
   endproperty
   a_opt_protect: assert property (p_opt_protect) else $error("protected word changed");
   property p_opt_commit;
      $changed(option_word) |-> $past(ctrl_wr && bus_wdata == 8'h00);
   endproperty
   a_opt_commit: assert property (p_opt_commit) else $error("word changed early");
   property p_reject;
      write_rejected |-> bus_write && (option_word_protect || block_protect_control != 4'h0);
   endproperty
   a_reject: assert property (p_reject) else $error("reject without write");
endmodule

bind eeps_sequencer eeps_checker #(.HV_COUNT(HV_COUNT)) i_eeps_checker (.clk, .reset_n,
   .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata, .bus_hit, .option_word_protect,
   .block_protect_control, .security_enable, .rom_based_part, .mode_expanded,
   .program_voltage_on, .hv_time_done,
   .write_rejected, .option_word);

//--- eeps_cpu_model.sv
// Processor model issuing control and array accesses.
module eeps_cpu_model
   import eeps_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        hv_time_done,
   input  wire logic [7:0]  bus_rdata,
   output logic      [15:0] bus_addr,
   output logic      [7:0]  bus_wdata,
   output logic             bus_write,
   output logic             bus_read
);
   timeunit 1ns;
   timeprecision 1ns;
   // Bus idles with no strobe.
   initial begin
      bus_addr = 16'h0000;
      bus_wdata = 8'h00;
      bus_write = 1'b0;
      bus_read = 1'b0;
   end
   // Released data is inverted so a stale value is never mistaken for fresh.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clk);
      bus_write <= 1'b0;
      bus_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk);
      bus_read <= 1'b0;
      @(negedge clk);
      d = bus_rdata;
   endtask
   // Full sequence: latch, target, voltage, timed wait, clear.
   task automatic run(input logic [7:0] m, input logic [15:0] a, input logic [7:0] v,
                      output bit ok);
      int n;
      logic [7:0] seen;
      wr(PROG_CTRL_ADDR, m);
      wr(a, v);
      wr(PROG_CTRL_ADDR, m | 8'h01);
      // A read of the target while latched must find the array hidden.
      rd(a, seen);
      n = 0;
      while (hv_time_done !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      ok = (hv_time_done === 1'b1) && (a == OPTION_WORD_ADDR || seen === 8'h00);
      wr(PROG_CTRL_ADDR, 8'h00);
   endtask
endmodule

//--- eeps_sequencer_tb_top.sv
// Self-checking bench for the erase and program sequencer.
module eeps_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import eeps_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [15:0] bus_addr;
   logic [7:0]  bus_wdata, bus_rdata, option_word, d;
   logic        bus_write, bus_read, bus_hit, program_voltage_on, hv_time_done;
   logic        write_rejected, mode_expanded;
   logic        option_word_protect = 1'b0, security_enable = 1'b0, rom_based_part = 1'b0;
   logic        mode_expanded_req = 1'b1;
   logic [3:0]  block_protect_control = 4'h0;
   bit          ok;
   int          mismatches = 0, check_count = 0;
   int          rejects = 0;
   // A short voltage phase keeps the run brief.
   always #5 clk = ~clk;
   // Counts refused target writes; each refusal stands for one bus cycle.
   always @(posedge clk) begin
      if (write_rejected === 1'b1)
         rejects <= rejects + 1;
   end
   eeps_sequencer #(.HV_COUNT(20)) i_eeps_sequencer (.clk, .reset_n, .bus_addr, .bus_wdata,
      .bus_write, .bus_read, .bus_rdata, .bus_hit, .option_word_protect, .block_protect_control,
      .security_enable, .rom_based_part, .mode_expanded_req, .mode_expanded,
      .program_voltage_on, .hv_time_done, .write_rejected, .option_word);
   eeps_cpu_model i_eeps_cpu_model (.clk, .hv_time_done, .bus_rdata, .bus_addr, .bus_wdata,
      .bus_write, .bus_read);
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
      i_eeps_cpu_model.rd(a, d);
      chk(d, exp);
   endtask
   // A voltage phase that never completes ends the run at once.
   task automatic op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] v);
      i_eeps_cpu_model.run(m, a, v, ok);
      chk({7'h00, ok}, 8'h01);
      if (!ok)
         conclude();
   endtask
   // Attempt on a protected target: the voltage bit is refused, so the wait runs out.
   task automatic try(input logic [7:0] m, input logic [15:0] a);
      i_eeps_cpu_model.run(m, a, 8'h00, ok);
      chk({7'h00, ok}, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rdchk(PROG_CTRL_ADDR, PROG_CTRL_RESET);
      i_eeps_cpu_model.wr(PROG_CTRL_ADDR, 8'h03);
      rdchk(PROG_CTRL_ADDR, 8'h00);
      $display("test refusal done");
      op(8'h06, 16'hB7F0, 8'h00);
      op(8'h02, 16'hB650, 8'h3C);
      op(8'h02, 16'hB660, 8'h0F);
      rdchk(16'hB650, 8'h3C);
      i_eeps_cpu_model.wr(PROG_CTRL_ADDR, 8'h0E);
      rdchk(16'hB660, 8'h00);
      op(8'h0E, 16'hB65A, 8'h77);
      rdchk(16'hB650, ERASED_BYTE);
      rdchk(16'hB660, 8'h0F);
      op(8'h16, 16'hB660, 8'h00);
      rdchk(16'hB660, ERASED_BYTE);
      $display("test array done");
      op(8'h16, OPTION_WORD_ADDR, 8'h00);
      op(8'h02, OPTION_WORD_ADDR, 8'hA5);
      @(negedge clk) chk(option_word, 8'hA5);
      chk(8'(rejects), 8'h00);
      @(posedge clk) option_word_protect <= 1'b1;
      try(8'h16, OPTION_WORD_ADDR);
      @(negedge clk) chk(option_word, 8'hA5);
      chk(8'(rejects), 8'h01);
      @(posedge clk) block_protect_control <= 4'h1;
      try(8'h02, 16'hB600);
      rdchk(16'hB600, ERASED_BYTE);
      chk(8'(rejects), 8'h02);
      $display("test protect done");
      @(posedge clk) security_enable <= 1'b1;
      @(posedge clk) rom_based_part <= 1'b1;
      @(negedge clk) chk({7'h00, mode_expanded}, 8'h00);
      rdchk(16'hB660, ERASED_BYTE);
      @(posedge clk) rom_based_part <= 1'b0;
      @(negedge clk) chk({7'h00, mode_expanded}, 8'h01);
      $display("test security done");
      conclude();
   end
endmodule
